// File: bench/amd_decoder_asserts.sv
// port assertions for the addressing mode decoder
module amd_decoder_asserts (
    input wire logic clock,
    input wire logic rst,
    input wire logic busy,
    input wire logic done,
    input wire logic prog_req,
    input wire logic prog_ack,
    input wire logic [15:0] prog_addr,
    input wire logic data_req,
    input wire logic data_ack,
    input wire logic [15:0] data_addr,
    input wire logic [4:0] mode,
    input wire logic [2:0] instr_len,
    input wire logic [15:0] eff_addr,
    input wire logic [7:0] operand,
    input wire logic [15:0] branch_target,
    input wire logic [15:0] next_pc,
    input wire logic [7:0] opcode,
    input wire logic use_alt_index,
    input wire logic illegal_reset,
    input wire logic halt_req,
    input wire logic wait_req
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    property p_prog_stand;
        prog_req && !prog_ack |=> prog_req && $stable(prog_addr);
    endproperty
    a_prog_stand: assert property (p_prog_stand) else $error("fetch dropped");

    property p_prog_step;
        prog_req && prog_ack |=> !prog_req || prog_addr == $past(prog_addr) + 16'h1;
    endproperty
    a_prog_step: assert property (p_prog_step) else $error("fetch order");

    property p_data_page;
        data_req |-> data_addr[15:8] == amd_pkg::PAGE_ZERO;
    endproperty
    a_data_page: assert property (p_data_page) else $error("pointer off page");

    property p_data_stand;
        data_req && !data_ack |=> data_req && $stable(data_addr);
    endproperty
    a_data_stand: assert property (p_data_stand) else $error("pointer read dropped");

    property p_done_pulse;
        done |-> !busy ##1 !done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done shape");

    property p_len;
        done |-> instr_len inside {[3'h1:3'h4]};
    endproperty
    a_len: assert property (p_len) else $error("length range");

    property p_busy_bound;
        $rose(busy) |-> ##[1:60] !busy;
    endproperty
    a_busy_bound: assert property (p_busy_bound) else $error("decode hangs");

    property p_dir_short;
        done && mode == amd_pkg::M_DIR_SHORT |-> eff_addr == {8'h00, operand};
    endproperty
    a_dir_short: assert property (p_dir_short) else $error("short direct address");

    property p_rel;
        done && mode == amd_pkg::M_REL_DIR |->
            branch_target == next_pc + {{8{operand[7]}}, operand} && eff_addr == branch_target;
    endproperty
    a_rel: assert property (p_rel) else $error("relative target");

    property p_alt_clear;
        done |=> !use_alt_index;
    endproperty
    a_alt_clear: assert property (p_alt_clear) else $error("prefix kept");

    property p_illegal;
        illegal_reset |-> !busy && !done ##1 !illegal_reset;
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal pulse");

    property p_power;
        halt_req || wait_req |-> done && opcode == (halt_req ? amd_pkg::HALT_OP : amd_pkg::WAIT_OP);
    endproperty
    a_power: assert property (p_power) else $error("power request");

    c_ind_long: cover property (done && mode == amd_pkg::M_IND_LONG);
    c_illegal: cover property (illegal_reset);
    c_halt: cover property (halt_req);
endmodule // amd_decoder_asserts

// File: bench/amd_mem_model.sv
// program and data memory behind the decoder, optional wait states
module amd_mem_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic slow,
    input wire logic prog_req,
    input wire logic [15:0] prog_addr,
    output logic prog_ack,
    output logic [7:0] prog_rdata,
    input wire logic data_req,
    input wire logic [15:0] data_addr,
    output logic data_ack,
    output logic [7:0] data_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [65536];
    logic [1:0] pw_q;
    logic [1:0] dw_q;
    logic [1:0] lim;

    assign lim = slow ? 2'h3 : 2'h0;

    // released data lines invert their previous value every cycle
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            {prog_ack, data_ack, prog_rdata, data_rdata, pw_q, dw_q} <= '0;
        end
        else
        begin
            prog_ack <= 1'b0;
            data_ack <= 1'b0;
            prog_rdata <= ~prog_rdata;
            data_rdata <= ~data_rdata;
            if (prog_req && !prog_ack)
            begin
                pw_q <= (pw_q == lim) ? 2'h0 : pw_q + 2'h1;
                prog_ack <= (pw_q == lim);
                if (pw_q == lim)
                    prog_rdata <= mem[prog_addr];
            end
            if (data_req && !data_ack)
            begin
                dw_q <= (dw_q == lim) ? 2'h0 : dw_q + 2'h1;
                data_ack <= (dw_q == lim);
                if (dw_q == lim)
                    data_rdata <= mem[data_addr];
            end
        end
    end
endmodule // amd_mem_model

// File: bench/test_addressing_mode_decoder.sv
// self-checking bench for the addressing mode decoder
module test_addressing_mode_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic slow = 1'b0;
    logic [15:0] start_pc = 16'h0000;
    logic [7:0] index_x = 8'h00;
    logic [7:0] index_y = 8'h00;
    logic prog_req, prog_ack, data_req, data_ack, busy, done, use_alt_index;
    logic illegal_reset, halt_req, wait_req, got_ill, got_halt, got_wait, got_alt;
    logic [7:0] prog_rdata, data_rdata, opcode, operand;
    logic [15:0] prog_addr, data_addr, eff_addr, branch_target, next_pc;
    logic [4:0] mode;
    logic [2:0] instr_len;
    int fails = 0;
    int checks_done = 0;

    always #20 clock = ~clock;

    amd_decoder u_dut (.clock(clock), .rst(rst), .start(start), .start_pc(start_pc),
        .index_x(index_x), .index_y(index_y), .prog_req(prog_req), .prog_addr(prog_addr),
        .prog_ack(prog_ack), .prog_rdata(prog_rdata), .data_req(data_req),
        .data_addr(data_addr), .data_ack(data_ack), .data_rdata(data_rdata), .busy(busy),
        .done(done), .opcode(opcode), .mode(mode), .instr_len(instr_len),
        .use_alt_index(use_alt_index), .eff_addr(eff_addr), .operand(operand),
        .branch_target(branch_target), .next_pc(next_pc), .illegal_reset(illegal_reset),
        .halt_req(halt_req), .wait_req(wait_req));

    amd_mem_model u_mem (.clock(clock), .rst(rst), .slow(slow), .prog_req(prog_req),
        .prog_addr(prog_addr), .prog_ack(prog_ack), .prog_rdata(prog_rdata),
        .data_req(data_req), .data_addr(data_addr), .data_ack(data_ack),
        .data_rdata(data_rdata));

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic go(input logic [15:0] pc, input logic [31:0] c);
        int i;
        for (i = 0; i < 4; i++)
            u_mem.mem[pc + i] = c[31 - 8 * i -: 8];
        @(posedge clock);
        start <= 1'b1;
        start_pc <= pc;
        @(posedge clock);
        start <= 1'b0;
        got_alt = 1'b0;
        for (i = 0; i < 100; i++)
        begin
            @(negedge clock);
            if (use_alt_index === 1'b1)
                got_alt = 1'b1;
            if (done === 1'b1 || illegal_reset === 1'b1)
                break;
        end
        got_ill = illegal_reset;
        got_halt = halt_req;
        got_wait = wait_req;
        if (i == 100)
        begin
            fails++;
            $display("ERROR t=%0t hang got=%h exp=%h", $time, 1'b0, 1'b1);
            close_out();
        end
    endtask

    // eff_addr is only judged where the mode defines an address
    task automatic dec(input logic [15:0] pc, input logic [31:0] c, input logic [15:0] ea,
        input logic [2:0] ln, input logic [4:0] md);
        go(pc, c);
        chk(got_ill, 1'b0);
        chk(instr_len, ln);
        chk(mode, md);
        chk(next_pc, pc + ln);
        if (md != amd_pkg::M_INHERENT && md != amd_pkg::M_IMMEDIATE)
            chk(eff_addr, ea);
    endtask

    task automatic idx(input logic [7:0] x, input logic [7:0] y, input logic s);
        @(posedge clock);
        index_x <= x;
        index_y <= y;
        slow <= s;
    endtask

    task automatic t_direct();
        dec(16'h0200, 32'h9d000000, 16'h0, 3'h1, amd_pkg::M_INHERENT);
        dec(16'h0210, 32'ha6550000, 16'h0, 3'h2, amd_pkg::M_IMMEDIATE);
        chk(operand, 8'h55);
        dec(16'h0220, 32'hb6800000, 16'h0080, 3'h2, amd_pkg::M_DIR_SHORT);
        dec(16'h0224, 32'h3c800000, 16'h0080, 3'h2, amd_pkg::M_DIR_SHORT);
        dec(16'h0228, 32'h10800000, 16'h0080, 3'h2, amd_pkg::M_BIT_DIR);
        idx(8'h00, 8'h00, 1'b1);
        dec(16'h0230, 32'hc6123400, 16'h1234, 3'h3, amd_pkg::M_DIR_LONG);
        $display("test direct done");
    endtask

    task automatic t_index();
        idx(8'hff, 8'h01, 1'b0);
        dec(16'h0300, 32'hf6000000, 16'h00ff, 3'h1, amd_pkg::M_IDX_NONE);
        dec(16'h0310, 32'he6ff0000, 16'h01fe, 3'h2, amd_pkg::M_IDX_SHORT);
        dec(16'h0320, 32'hd6120000, 16'h12ff, 3'h3, amd_pkg::M_IDX_LONG);
        dec(16'h0330, 32'h90d61234, 16'h1235, 3'h4, amd_pkg::M_IDX_LONG);
        dec(16'h0340, 32'h90f60000, 16'h0001, 3'h2, amd_pkg::M_IDX_NONE);
        chk(got_alt, 1'b1);
        dec(16'h0350, 32'hf6000000, 16'h00ff, 3'h1, amd_pkg::M_IDX_NONE);
        chk(got_alt, 1'b0);
        $display("test index done");
    endtask

    task automatic t_indirect();
        u_mem.mem[16'h0010] = 8'hab;
        u_mem.mem[16'h0011] = 8'hcd;
        u_mem.mem[16'h00ff] = 8'h12;
        u_mem.mem[16'h0000] = 8'h34;
        dec(16'h0400, 32'h92b61000, 16'h00ab, 3'h3, amd_pkg::M_IND_SHORT);
        dec(16'h0410, 32'h92c6ff00, 16'h1234, 3'h3, amd_pkg::M_IND_LONG);
        dec(16'h0420, 32'h92e61000, 16'h01aa, 3'h3, amd_pkg::M_INDIDX_SHORT);
        dec(16'h0430, 32'h92d61000, 16'haccc, 3'h3, amd_pkg::M_INDIDX_LONG);
        dec(16'h0440, 32'h91e61000, 16'h00ac, 3'h3, amd_pkg::M_INDIDX_SHORT);
        dec(16'h0450, 32'h92101000, 16'h00ab, 3'h3, amd_pkg::M_BIT_IND);
        dec(16'h0460, 32'h920010fe, 16'h00ab, 3'h4, amd_pkg::M_BITREL_IND);
        $display("test indirect done");
    endtask

    task automatic t_relative();
        u_mem.mem[16'h0040] = 8'hfe;
        dec(16'h0500, 32'h20800000, 16'h0482, 3'h2, amd_pkg::M_REL_DIR);
        chk(branch_target, 16'h0482);
        dec(16'h0510, 32'h207f0000, 16'h0591, 3'h2, amd_pkg::M_REL_DIR);
        dec(16'h0520, 32'h92204000, 16'h0521, 3'h3, amd_pkg::M_REL_IND);
        dec(16'h0530, 32'had050000, 16'h0537, 3'h2, amd_pkg::M_REL_DIR);
        dec(16'h0540, 32'h00800500, 16'h0080, 3'h3, amd_pkg::M_BITREL_DIR);
        chk(branch_target, 16'h0548);
        $display("test relative done");
    endtask

    task automatic t_special();
        dec(16'h0600, 32'h8e000000, 16'h0, 3'h1, amd_pkg::M_INHERENT);
        chk({got_halt, got_wait}, 2'b10);
        dec(16'h0610, 32'h8f000000, 16'h0, 3'h1, amd_pkg::M_INHERENT);
        chk({got_halt, got_wait}, 2'b01);
        go(16'h0620, 32'h31000000);
        chk(got_ill, 1'b1);
        dec(16'h0630, 32'h92a65500, 16'h0, 3'h3, amd_pkg::M_IMMEDIATE);
        $display("test special done");
    endtask

    initial
    begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        t_direct();
        t_index();
        t_indirect();
        t_relative();
        t_special();
        close_out();
    end
endmodule // test_addressing_mode_decoder

bind amd_decoder amd_decoder_asserts u_chk (.clock(clock), .rst(rst), .busy(busy),
    .done(done), .prog_req(prog_req), .prog_ack(prog_ack), .prog_addr(prog_addr),
    .data_req(data_req), .data_ack(data_ack), .data_addr(data_addr), .mode(mode),
    .instr_len(instr_len), .eff_addr(eff_addr), .operand(operand),
    .branch_target(branch_target), .next_pc(next_pc), .opcode(opcode),
    .use_alt_index(use_alt_index), .illegal_reset(illegal_reset), .halt_req(halt_req),
    .wait_req(wait_req));

// File: verilog/amd_decoder.sv
// addressing mode decoder: fetches one instruction, resolves its effective address
// Behaviour
// - inherent instructions are one byte, no operand bytes fetched
// - immediate fetches one byte used directly as operand value
// - short direct takes one address byte, page zero only
// - long direct takes a two byte address anywhere in 64K
// - indexed address is unsigned sum of chosen index and offset
// - no-offset indexed fetches nothing, index alone is the address
// - short indexed adds one offset byte, reaching up to 1fe
// - long indexed adds a two byte offset word to index
// - short indirect reads a one byte pointer from page zero
// - long indirect reads a two byte pointer from page zero
// - indirect indexed adds index to fetched pointer, short reaches 1fe
// - relative forms add an 8-bit signed offset to program counter
// - direct relative offset follows opcode, indirect relative reads it
// - instructions are one to four bytes including prefix
// - layout is optional prefix, opcode, then zero to two bytes
// - prefix 90 selects alternate index register
// - prefix 92 turns direct and offset indexed forms into indirect forms, no-offset indexed stays as is
// - prefix 91 turns indirect indexed form onto alternate index
// - opcode set of 63 instructions in 13 groups recognised
// - halt requests lowest power state, wait requests lighter one
// - relative offset applies to address after the branch
// - read-modify-write opcodes exist only in short addressing forms
// - byte neither opcode nor prefix raises reset request
module amd_decoder (
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire logic [15:0] start_pc,
    input wire logic [7:0] index_x,
    input wire logic [7:0] index_y,
    output logic prog_req,
    output logic [15:0] prog_addr,
    input wire logic prog_ack,
    input wire logic [7:0] prog_rdata,
    output logic data_req,
    output logic [15:0] data_addr,
    input wire logic data_ack,
    input wire logic [7:0] data_rdata,
    output logic busy,
    output logic done,
    output logic [7:0] opcode,
    output logic [4:0] mode,
    output logic [2:0] instr_len,
    output logic use_alt_index,
    output logic [15:0] eff_addr,
    output logic [7:0] operand,
    output logic [15:0] branch_target,
    output logic [15:0] next_pc,
    output logic illegal_reset,
    output logic halt_req,
    output logic wait_req
);

    amd_pkg::amd_regs_type q;
    amd_pkg::amd_regs_type n;

    amd_pkg::amd_mode_type base_mode;
    amd_pkg::amd_mode_type dec_mode;
    logic is_prefix;
    logic is_legal;
    logic [1:0] dec_nopd;
    logic [1:0] dec_nptr;
    logic [7:0] ptr_loc;
    logic [7:0] idx;
    logic [7:0] rel_off;

    // bytes following the opcode
    function automatic logic [1:0] opd_bytes(input amd_pkg::amd_mode_type m);
        case (m)
            amd_pkg::M_INHERENT, amd_pkg::M_IDX_NONE: opd_bytes = 2'h0;
            amd_pkg::M_DIR_LONG, amd_pkg::M_IDX_LONG: opd_bytes = 2'h2;
            amd_pkg::M_BITREL_DIR, amd_pkg::M_BITREL_IND: opd_bytes = 2'h2;
            default: opd_bytes = 2'h1;
        endcase
    endfunction

    // pointer bytes read from page zero
    function automatic logic [1:0] ptr_bytes(input amd_pkg::amd_mode_type m);
        case (m)
            amd_pkg::M_IND_LONG, amd_pkg::M_INDIDX_LONG: ptr_bytes = 2'h2;
            amd_pkg::M_IND_SHORT, amd_pkg::M_INDIDX_SHORT: ptr_bytes = 2'h1;
            amd_pkg::M_REL_IND, amd_pkg::M_BIT_IND: ptr_bytes = 2'h1;
            amd_pkg::M_BITREL_IND: ptr_bytes = 2'h1;
            default: ptr_bytes = 2'h0;
        endcase
    endfunction

    // opcode classification from the byte on the fetch bus
    always_comb
    begin
        is_prefix = (prog_rdata == amd_pkg::PRE_ALT_REG) || (prog_rdata == amd_pkg::PRE_ALT_IND)
            || (prog_rdata == amd_pkg::PRE_IND);
        is_legal = amd_pkg::LEGAL_MAP[prog_rdata[7:4]][prog_rdata[3:0]];
        // rmw columns carry only short and no-offset forms
        base_mode = amd_pkg::COL_MODE[prog_rdata[7:4]];
        if (prog_rdata == amd_pkg::REL_CALL_OP)
        begin
            base_mode = amd_pkg::M_REL_DIR;
        end
        dec_mode = base_mode;
        case (q.pre)
            amd_pkg::PRE_IX:
            begin
                case (base_mode)
                    amd_pkg::M_DIR_SHORT: dec_mode = amd_pkg::M_IND_SHORT;
                    amd_pkg::M_DIR_LONG: dec_mode = amd_pkg::M_IND_LONG;
                    amd_pkg::M_BIT_DIR: dec_mode = amd_pkg::M_BIT_IND;
                    amd_pkg::M_BITREL_DIR: dec_mode = amd_pkg::M_BITREL_IND;
                    amd_pkg::M_REL_DIR: dec_mode = amd_pkg::M_REL_IND;
                    amd_pkg::M_IDX_SHORT: dec_mode = amd_pkg::M_INDIDX_SHORT;
                    amd_pkg::M_IDX_LONG: dec_mode = amd_pkg::M_INDIDX_LONG;
                    default: dec_mode = base_mode;
                endcase
            end
            amd_pkg::PRE_IY:
            begin
                case (base_mode)
                    amd_pkg::M_IDX_SHORT: dec_mode = amd_pkg::M_INDIDX_SHORT;
                    amd_pkg::M_IDX_LONG: dec_mode = amd_pkg::M_INDIDX_LONG;
                    default: dec_mode = base_mode;
                endcase
            end
            default: dec_mode = base_mode;
        endcase
        dec_nopd = opd_bytes(dec_mode);
        dec_nptr = ptr_bytes(dec_mode);
    end

    // pointer location, index and branch offset
    always_comb
    begin
        ptr_loc = (q.cnt == 2'h1) ? prog_rdata : q.opd[0];
        idx = q.alt ? index_y : index_x;
        case (q.mode)
            amd_pkg::M_REL_IND: rel_off = q.ptr[7:0];
            amd_pkg::M_BITREL_DIR, amd_pkg::M_BITREL_IND: rel_off = q.opd[1];
            default: rel_off = q.opd[0];
        endcase
    end

    always_comb
    begin
        n = q;
        n.done = 1'b0;
        n.illegal = 1'b0;
        n.halt_req = 1'b0;
        n.wait_req = 1'b0;
        case (q.st)
            amd_pkg::ST_IDLE:
            begin
                if (start)
                begin
                    n.st = amd_pkg::ST_FETCH;
                    n.prog_req = 1'b1;
                    n.prog_addr = start_pc;
                    n.cnt = 2'h0;
                    n.pcnt = 1'b0;
                    n.ptr = 16'h0000;
                    n.opd = '0;
                    n.pre = amd_pkg::PRE_NONE;
                    // no index choice carries over
                    n.alt = 1'b0;
                end
            end
            amd_pkg::ST_FETCH:
            begin
                if (prog_ack)
                begin
                    n.prog_addr = q.prog_addr + 16'h0001;
                    if (q.cnt == 2'h0)
                    begin
                        if (is_prefix && (q.pre == amd_pkg::PRE_NONE))
                        begin
                            case (prog_rdata)
                                amd_pkg::PRE_ALT_REG: n.pre = amd_pkg::PRE_Y;
                                amd_pkg::PRE_ALT_IND: n.pre = amd_pkg::PRE_IY;
                                default: n.pre = amd_pkg::PRE_IX;
                            endcase
                            n.alt = (prog_rdata != amd_pkg::PRE_IND);
                        end
                        else if (!is_legal && !is_prefix)
                        begin
                            n.illegal = 1'b1;
                            n.st = amd_pkg::ST_IDLE;
                            n.prog_req = 1'b0;
                            n.pre = amd_pkg::PRE_NONE;
                            n.alt = 1'b0;
                        end
                        else
                        begin
                            n.opc = prog_rdata;
                            n.mode = dec_mode;
                            n.nopd = dec_nopd;
                            n.nptr = dec_nptr;
                            n.cnt = 2'h1;
                            if (dec_nopd == 2'h0)
                            begin
                                n.prog_req = 1'b0;
                                n.st = amd_pkg::ST_CALC;
                            end
                        end
                    end
                    else
                    begin
                        // first byte after opcode is a word's high half
                        if (q.cnt == 2'h1)
                        begin
                            n.opd[0] = prog_rdata;
                        end
                        else
                        begin
                            n.opd[1] = prog_rdata;
                        end
                        n.cnt = q.cnt + 2'h1;
                        if (q.cnt == q.nopd)
                        begin
                            n.prog_req = 1'b0;
                            if (q.nptr != 2'h0)
                            begin
                                n.st = amd_pkg::ST_PTR;
                                n.data_req = 1'b1;
                                n.data_addr = {amd_pkg::PAGE_ZERO, ptr_loc};
                            end
                            else
                            begin
                                n.st = amd_pkg::ST_CALC;
                            end
                        end
                    end
                end
            end
            amd_pkg::ST_PTR:
            begin
                if (data_ack)
                begin
                    if ((q.nptr == 2'h2) && !q.pcnt)
                    begin
                        n.ptr[15:8] = data_rdata;
                        n.pcnt = 1'b1;
                        // low pointer byte wraps inside page zero
                        n.data_addr = {amd_pkg::PAGE_ZERO, q.data_addr[7:0] + 8'h01};
                    end
                    else
                    begin
                        n.ptr[7:0] = data_rdata;
                        n.data_req = 1'b0;
                        n.st = amd_pkg::ST_CALC;
                    end
                end
            end
            amd_pkg::ST_CALC:
            begin
                n.st = amd_pkg::ST_IDLE;
                n.done = 1'b1;
                n.operand = q.opd[0];
                // a prefix adds one byte
                n.len = amd_pkg::OPCODE_LEN + {1'b0, q.nopd};
                if (q.pre != amd_pkg::PRE_NONE)
                begin
                    n.len = n.len + 3'h1;
                end
                // prog_addr already points past the branch here
                n.target = q.prog_addr + {{8{rel_off[7]}}, rel_off};
                case (q.mode)
                    amd_pkg::M_DIR_SHORT, amd_pkg::M_BIT_DIR, amd_pkg::M_BITREL_DIR:
                        n.eff_addr = {amd_pkg::PAGE_ZERO, q.opd[0]};
                    amd_pkg::M_DIR_LONG: n.eff_addr = {q.opd[0], q.opd[1]};
                    amd_pkg::M_IDX_NONE: n.eff_addr = {amd_pkg::PAGE_ZERO, idx};
                    amd_pkg::M_IDX_SHORT:
                        n.eff_addr = {7'h00, {1'b0, idx} + {1'b0, q.opd[0]}};
                    amd_pkg::M_IDX_LONG:
                        n.eff_addr = {q.opd[0], q.opd[1]} + {8'h00, idx};
                    amd_pkg::M_IND_SHORT, amd_pkg::M_BIT_IND, amd_pkg::M_BITREL_IND:
                        n.eff_addr = {amd_pkg::PAGE_ZERO, q.ptr[7:0]};
                    amd_pkg::M_IND_LONG: n.eff_addr = q.ptr;
                    amd_pkg::M_INDIDX_SHORT:
                        n.eff_addr = {7'h00, {1'b0, idx} + {1'b0, q.ptr[7:0]}};
                    amd_pkg::M_INDIDX_LONG: n.eff_addr = q.ptr + {8'h00, idx};
                    amd_pkg::M_REL_DIR, amd_pkg::M_REL_IND: n.eff_addr = n.target;
                    default: n.eff_addr = 16'h0000;
                endcase
                if (q.pre == amd_pkg::PRE_NONE)
                begin
                    n.halt_req = (q.opc == amd_pkg::HALT_OP);
                    n.wait_req = (q.opc == amd_pkg::WAIT_OP);
                end
                n.pre = amd_pkg::PRE_NONE;
                n.alt = 1'b0;
                n.cnt = 2'h0;
            end
            default:
            begin
                // unreachable state, drop both requests
                n.st = amd_pkg::ST_IDLE;
                n.prog_req = 1'b0;
                n.data_req = 1'b0;
            end
        endcase
        // busy leaves from a flop like every port
        n.busy = (n.st != amd_pkg::ST_IDLE);
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            q <= '{
                st: amd_pkg::ST_IDLE,
                pre: amd_pkg::PRE_NONE,
                mode: amd_pkg::M_INHERENT,
                prog_addr: amd_pkg::RESET_ADDR,
                default: '0
            };
        end
        else
        begin
            q <= n;
        end
    end

    assign prog_req = q.prog_req;
    assign prog_addr = q.prog_addr;
    assign data_req = q.data_req;
    assign data_addr = q.data_addr;
    assign busy = q.busy;
    assign done = q.done;
    assign opcode = q.opc;
    assign mode = q.mode;
    assign instr_len = q.len;
    assign use_alt_index = q.alt;
    assign eff_addr = q.eff_addr;
    assign operand = q.operand;
    assign branch_target = q.target;
    assign next_pc = q.prog_addr;
    assign illegal_reset = q.illegal;
    assign halt_req = q.halt_req;
    assign wait_req = q.wait_req;

endmodule // amd_decoder

// File: verilog/amd_pkg.sv
// constants, modes, states and state record of the addressing mode decoder
package amd_pkg;

    localparam logic [7:0] PRE_ALT_REG = 8'h90;
    localparam logic [7:0] PRE_ALT_IND = 8'h91;
    localparam logic [7:0] PRE_IND = 8'h92;
    localparam logic [7:0] HALT_OP = 8'h8e;
    localparam logic [7:0] WAIT_OP = 8'h8f;
    localparam logic [7:0] REL_CALL_OP = 8'had;
    localparam logic [7:0] PAGE_ZERO = 8'h00;
    localparam logic [2:0] OPCODE_LEN = 3'h1;
    localparam logic [15:0] RESET_ADDR = 16'h0000;

    typedef enum logic [4:0] {
        M_INHERENT = 5'h00,
        M_IMMEDIATE = 5'h01,
        M_DIR_SHORT = 5'h02,
        M_DIR_LONG = 5'h03,
        M_IDX_NONE = 5'h04,
        M_IDX_SHORT = 5'h05,
        M_IDX_LONG = 5'h06,
        M_IND_SHORT = 5'h07,
        M_IND_LONG = 5'h08,
        M_INDIDX_SHORT = 5'h09,
        M_INDIDX_LONG = 5'h0a,
        M_REL_DIR = 5'h0b,
        M_REL_IND = 5'h0c,
        M_BIT_DIR = 5'h0d,
        M_BIT_IND = 5'h0e,
        M_BITREL_DIR = 5'h0f,
        M_BITREL_IND = 5'h10
    } amd_mode_type;

    // base mode per opcode high nibble, before any prefix
    localparam amd_mode_type COL_MODE [16] = '{
        M_BITREL_DIR, M_BIT_DIR, M_REL_DIR, M_DIR_SHORT,
        M_INHERENT, M_INHERENT, M_IDX_SHORT, M_IDX_NONE,
        M_INHERENT, M_INHERENT, M_IMMEDIATE, M_DIR_SHORT,
        M_DIR_LONG, M_IDX_LONG, M_IDX_SHORT, M_IDX_NONE
    };

    // defined low nibbles per high nibble, bit n set when opcode xn exists
    localparam logic [15:0] LEGAL_MAP [16] = '{
        16'hffff, 16'hffff, 16'hffff, 16'hf7d9,
        16'hf7d9, 16'hf7d9, 16'hf7d9, 16'hf7d9,
        16'hf00f, 16'hfff8, 16'haf7f, 16'hffff,
        16'hffff, 16'hffff, 16'hffff, 16'hffff
    };

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_PTR = 2'b11,
        ST_CALC = 2'b10
    } amd_state_type;

    typedef enum logic [1:0] {
        PRE_NONE = 2'h0,
        PRE_Y = 2'h1,
        PRE_IX = 2'h2,
        PRE_IY = 2'h3
    } amd_pre_type;

    typedef struct packed {
        amd_state_type st;
        amd_pre_type pre;
        logic [1:0] cnt;
        logic [1:0] nopd;
        logic [1:0] nptr;
        logic pcnt;
        logic [1:0][7:0] opd;
        logic [15:0] ptr;
        logic [7:0] opc;
        amd_mode_type mode;
        logic prog_req;
        logic [15:0] prog_addr;
        logic data_req;
        logic [15:0] data_addr;
        logic done;
        logic busy;
        logic illegal;
        logic halt_req;
        logic wait_req;
        logic alt;
        logic [2:0] len;
        logic [15:0] eff_addr;
        logic [7:0] operand;
        logic [15:0] target;
    } amd_regs_type;

endpackage
